// ---- src/rf_pkg.sv ----
// Shared constants of the rangefinder error and switching-input logic.
// Assumes one device clock; parameter indices match the fieldbus parameter object.
package rf_pkg;

  localparam int unsigned POS_W      = 24;
  localparam int unsigned PAR_W      = 8;
  localparam int unsigned NUM_STAT   = 7;

  // Parameter object instance numbers
  localparam logic [7:0] IDX_SW_FUNC    = 8'h0a;
  localparam logic [7:0] IDX_AUTO_ACK   = 8'h0b;
  localparam logic [7:0] IDX_ERR_FUNC   = 8'h0c;
  localparam logic [7:0] IDX_SUBST      = 8'h0d;
  localparam logic [7:0] IDX_STAT_BUS   = 8'h0e;
  localparam logic [7:0] IDX_INTENSITY  = 8'h0f;

  // Reset values
  localparam logic [7:0] RST_SW_FUNC    = 8'h00;
  localparam logic [7:0] RST_AUTO_ACK   = 8'h00;
  localparam logic [7:0] RST_ERR_FUNC   = 8'h00;
  localparam logic [7:0] RST_SUBST      = 8'h00;
  localparam logic [7:0] RST_STAT_BUS   = 8'h00;

  // Switch-input functions
  localparam logic [7:0] SWF_OFF        = 8'h00;
  localparam logic [7:0] SWF_PRESET     = 8'h01;
  localparam logic [7:0] SWF_LD_OFF     = 8'h02;
  localparam logic [7:0] SWF_ACK        = 8'h03;

  // Error output functions
  localparam logic [7:0] EOF_OFF        = 8'h00;
  localparam logic [7:0] EOF_TEMP       = 8'h01;
  localparam logic [7:0] EOF_INTENS     = 8'h02;
  localparam logic [7:0] EOF_HW         = 8'h03;
  localparam logic [7:0] EOF_ANY        = 8'h04;
  localparam logic [7:0] EOF_SPEED      = 8'h05;
  localparam logic [7:0] EOF_PLAUS      = 8'h06;

  // Substitute value choices
  localparam logic [7:0] SUB_ZERO       = 8'h00;
  localparam logic [7:0] SUB_ONES       = 8'h01;
  localparam logic [7:0] SUB_LAST       = 8'h02;

  // Status byte bit positions
  localparam int unsigned SB_INTENS     = 0;
  localparam int unsigned SB_TEMP       = 1;
  localparam int unsigned SB_HW         = 2;
  localparam int unsigned SB_LD_OFF     = 3;
  localparam int unsigned SB_INT_WARN   = 4;
  localparam int unsigned SB_SPEED      = 5;
  localparam int unsigned SB_PLAUS      = 6;

  // Intensity thresholds in percent
  localparam logic [7:0] INT_ERR_PCT    = 8'h08;
  localparam logic [7:0] INT_WARN_PCT   = 8'h0c;
  localparam logic [7:0] INT_MAX_PCT    = 8'h64;

endpackage : rf_pkg

// ---- src/rf_sync2.sv ----
// Two-flop synchroniser for the external switching input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module rf_sync2 (
  input  wire logic clk,    // Device clock
  input  wire logic nrst,   // Async reset, active low
  input  wire logic d,      // Asynchronous level
  output logic      q       // Synchronised level
);
  logic meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : rf_sync2

// ---- src/rf_status_bit.sv ----
// One sticky status bit with optional acknowledge.
// Assumes cond and ack come from logic on clk.
`timescale 1ns/1ps
module rf_status_bit (
  input  wire logic clk,       // Device clock
  input  wire logic nrst,      // Async reset, active low
  input  wire logic cond,      // Condition present
  input  wire logic auto_ack,  // Clear without acknowledge
  input  wire logic ack,       // Acknowledge pulse
  output logic      flag       // Reported bit
);
  logic clr;

  // A present condition always wins over a clear
  assign clr = !cond && (auto_ack || ack);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (cond) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule : rf_status_bit

// ---- src/rf_error_io.sv ----
// Error handling, switching input and error output of the rangefinder.
// Assumes measurement core, fieldbus parameter access and output byte all run on clk;
// only the switching input pin is asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - Switch-input selector: 0 off, 1 preset, 2 diode off, 3 acknowledge; resets off.
// - In preset mode the input edge loads the preset as reported position.
// - In diode-off mode the active input switches the laser diode off.
// - Automatic diode switch-off in basic config makes the diode-off input ignored.
// - With manual acknowledge, errors stay until bus bit 3 or input acknowledge.
// - With automatic acknowledge, errors clear once their cause is gone.
// - Error output selector: off, temperature, intensity, hardware, any, overspeed, implausible.
// - Substitute selector: zero, all 24 bits one, or last valid position.
// - Substitute value replaces position whenever no valid measurement exists.
// - A setting places the status byte in the high byte of cyclic input data.
// - Status byte reads zero with no error, warning or laser diode switch-off.
// - Bits clear when condition ends; manually also needing an acknowledge.
// - Bit 0: intensity under 8 percent or beam interrupted; forces substitute.
// - Bit 1: temperature outside 0 to 50 C; low side only a warning.
// - Bit 2: internal hardware fault; forces substitute.
// - Bit 3: laser diode switched off from bus or input; information only.
// - Bit 4: intensity under 12 percent warning; measurement continues.
// - Bit 5: speed over service-set threshold; check off by default, not bus-set.
// - Bit 6: measurement implausible, e.g. jump from a second reflector.
// - Beam intensity readable as percentage, never above 100.
// - Position is 24 bits so all-ones substitute fills it exactly.
module rf_error_io
  import rf_pkg::*;
(
  input  wire logic                clk,             // Device clock, 25 MHz
  input  wire logic                nrst,            // Async reset, active low
  // Parameter access from the fieldbus
  input  wire logic                par_wr,          // Parameter write strobe
  input  wire logic [7:0]          par_idx,         // Parameter instance number
  input  wire logic [PAR_W-1:0]    par_wdata,       // Parameter write value
  output logic      [PAR_W-1:0]    par_rdata,       // Parameter read value
  // Cyclic output byte from the master
  input  wire logic                bus_ld_off,      // Output byte: laser diode off
  input  wire logic                bus_ack,         // Output byte bit 3: acknowledge
  // Service-interface configuration
  input  wire logic                auto_ld_off,     // Automatic diode switch-off enabled
  input  wire logic                speed_chk_en,    // Speed check enabled
  // Measurement core
  input  wire logic [POS_W-1:0]    meas_pos,        // Raw position
  input  wire logic                meas_valid,      // Raw position usable
  input  wire logic [7:0]          meas_intensity,  // Received intensity in percent
  input  wire logic                beam_lost,       // Beam interrupted
  input  wire logic                temp_high,       // Housing above 50 C
  input  wire logic                temp_low,        // Housing below 0 C
  input  wire logic                hw_fault,        // Internal hardware fault
  input  wire logic                overspeed,       // Speed over threshold
  input  wire logic                implausible,     // Measurement untrusted
  input  wire logic [POS_W-1:0]    preset_pos,      // Stored preset position
  // Pins
  input  wire logic                switch_in,       // External switching input pin
  output logic                     error_out,       // External error switching output
  output logic                     laser_diode_off, // Laser diode switch-off command
  // Results
  output logic      [POS_W-1:0]    position,        // Reported position
  output logic      [7:0]          status_byte,     // Error status byte
  output logic      [31:0]         cyclic_in        // Cyclic input data to master
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers
  logic [PAR_W-1:0] sw_func_r;
  logic [PAR_W-1:0] auto_ack_r;
  logic [PAR_W-1:0] err_func_r;
  logic [PAR_W-1:0] subst_r;
  logic [PAR_W-1:0] stat_bus_r;
  logic [7:0]       intensity_r;

  logic             wr_sw_func;
  logic             wr_auto_ack;
  logic             wr_err_func;
  logic             wr_subst;
  logic             wr_stat_bus;

  assign wr_sw_func  = par_wr && (par_idx == IDX_SW_FUNC);
  assign wr_auto_ack = par_wr && (par_idx == IDX_AUTO_ACK);
  assign wr_err_func = par_wr && (par_idx == IDX_ERR_FUNC);
  assign wr_subst    = par_wr && (par_idx == IDX_SUBST);
  assign wr_stat_bus = par_wr && (par_idx == IDX_STAT_BUS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_func_r <= RST_SW_FUNC;
    end else if (wr_sw_func) begin
      sw_func_r <= par_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_ack_r <= RST_AUTO_ACK;
    end else if (wr_auto_ack) begin
      auto_ack_r <= par_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_func_r <= RST_ERR_FUNC;
    end else if (wr_err_func) begin
      err_func_r <= par_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      subst_r <= RST_SUBST;
    end else if (wr_subst) begin
      subst_r <= par_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_bus_r <= RST_STAT_BUS;
    end else if (wr_stat_bus) begin
      stat_bus_r <= par_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Intensity report, clamped to 100
  logic [7:0] intensity_nxt;

  assign intensity_nxt = (meas_intensity > INT_MAX_PCT) ? INT_MAX_PCT : meas_intensity;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intensity_r <= 8'h00;
    end else begin
      intensity_r <= intensity_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter read-back
  logic [PAR_W-1:0] rdata_nxt;

  always_comb begin
    case (par_idx)
      IDX_SW_FUNC:   rdata_nxt = sw_func_r;
      IDX_AUTO_ACK:  rdata_nxt = auto_ack_r;
      IDX_ERR_FUNC:  rdata_nxt = err_func_r;
      IDX_SUBST:     rdata_nxt = subst_r;
      IDX_STAT_BUS:  rdata_nxt = stat_bus_r;
      IDX_INTENSITY: rdata_nxt = intensity_r;
      default:       rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      par_rdata <= 8'h00;
    end else begin
      par_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching input and acknowledge edges
  logic sw_sync;
  logic sw_prev_r;
  logic ack_prev_r;
  logic sw_rise;
  logic bus_ack_rise;
  logic ack_pulse;
  logic auto_ack;

  rf_sync2 u_sw_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (switch_in),
    .q    (sw_sync)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_prev_r  <= 1'b0;
      ack_prev_r <= 1'b0;
    end else begin
      sw_prev_r  <= sw_sync;
      ack_prev_r <= bus_ack;
    end
  end

  assign sw_rise      = sw_sync && !sw_prev_r;
  assign bus_ack_rise = bus_ack && !ack_prev_r;
  assign ack_pulse    = bus_ack_rise || (sw_rise && (sw_func_r == SWF_ACK));
  assign auto_ack     = (auto_ack_r != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Laser diode switch-off
  logic ld_off_in;
  logic ld_off_nxt;

  // Disabled selector leaves the input without effect
  assign ld_off_in  = sw_sync && (sw_func_r == SWF_LD_OFF) && !auto_ld_off;
  assign ld_off_nxt = bus_ld_off || ld_off_in;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      laser_diode_off <= 1'b0;
    end else begin
      laser_diode_off <= ld_off_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status conditions and sticky bits
  logic [NUM_STAT-1:0] cond;
  logic [NUM_STAT-1:0] flags;

  assign cond[SB_INTENS]   = (meas_intensity < INT_ERR_PCT) || beam_lost;
  assign cond[SB_TEMP]     = temp_high || temp_low;
  assign cond[SB_HW]       = hw_fault;
  assign cond[SB_LD_OFF]   = laser_diode_off;
  assign cond[SB_INT_WARN] = meas_intensity < INT_WARN_PCT;
  assign cond[SB_SPEED]    = overspeed && speed_chk_en;
  assign cond[SB_PLAUS]    = implausible;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STAT; gi++) begin : g_stat
      rf_status_bit u_bit (
        .clk      (clk),
        .nrst     (nrst),
        .cond     (cond[gi]),
        .auto_ack (auto_ack),
        .ack      (ack_pulse),
        .flag     (flags[gi])
      );
    end
  endgenerate

  logic [7:0] status_nxt;

  assign status_nxt = {1'b0, flags};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error switching output
  logic err_nxt;

  always_comb begin
    case (err_func_r)
      EOF_TEMP:   err_nxt = flags[SB_TEMP];
      EOF_INTENS: err_nxt = flags[SB_INTENS];
      EOF_HW:     err_nxt = flags[SB_HW];
      EOF_ANY:    err_nxt = |flags;
      EOF_SPEED:  err_nxt = flags[SB_SPEED];
      EOF_PLAUS:  err_nxt = flags[SB_PLAUS];
      default:    err_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      error_out <= 1'b0;
    end else begin
      error_out <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset offset
  logic [POS_W-1:0] offset_r;
  logic             preset_ev;

  assign preset_ev = sw_rise && (sw_func_r == SWF_PRESET);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_r <= '0;
    end else if (preset_ev) begin
      offset_r <= preset_pos - meas_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position and substitute value
  logic [POS_W-1:0] adj_pos;
  logic [POS_W-1:0] last_valid_r;
  logic [POS_W-1:0] subst_val;
  logic [POS_W-1:0] pos_nxt;
  logic             pos_ok;

  assign adj_pos = meas_pos + offset_r;
  // Intensity error and hardware fault force the substitute value
  assign pos_ok  = meas_valid && !cond[SB_INTENS] && !cond[SB_HW];

  always_comb begin
    case (subst_r)
      SUB_ONES: subst_val = {POS_W{1'b1}};
      SUB_LAST: subst_val = last_valid_r;
      default:  subst_val = '0;
    endcase
  end

  assign pos_nxt = pos_ok ? adj_pos : subst_val;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_valid_r <= '0;
    end else if (pos_ok) begin
      last_valid_r <= adj_pos;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      position <= '0;
    end else begin
      position <= pos_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic input data
  logic [31:0] cyclic_nxt;
  logic        stat_on_bus;

  assign stat_on_bus = (stat_bus_r != 8'h00);
  assign cyclic_nxt  = {(stat_on_bus ? status_nxt : 8'h00), pos_nxt};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyclic_in <= 32'h0000_0000;
    end else begin
      cyclic_in <= cyclic_nxt;
    end
  end

endmodule : rf_error_io

// ---- test/rf_error_io_assertions.sv ----
// Concurrent checks on the ports of the error and switching-input block.
// Assumes a single clock domain clk with async active-low nrst.
`timescale 1ns/1ps
module rf_err_chk
  import rf_pkg::*;
(
  input wire logic                   clk,             // Device clock
  input wire logic                   nrst,            // Async reset, active low
  input wire logic [7:0]             par_idx,         // Parameter instance
  input wire logic [rf_pkg::PAR_W-1:0] par_rdata,     // Parameter read value
  input wire logic                   bus_ld_off,      // Bus diode off
  input wire logic [7:0]             meas_intensity,  // Intensity percent
  input wire logic                   temp_high,       // Over temperature
  input wire logic                   hw_fault,        // Hardware fault
  input wire logic                   error_out,       // Error output pin
  input wire logic                   laser_diode_off, // Diode off command
  input wire logic [rf_pkg::POS_W-1:0] position,      // Reported position
  input wire logic [7:0]             status_byte,     // Status byte
  input wire logic [31:0]            cyclic_in        // Cyclic input data
);
  import rf_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_top_bit_zero: assert property (status_byte[7] == 1'b0)
    else $error("status bit 7 set");
  a_intens_max: assert property (par_idx == IDX_INTENSITY |=> par_rdata <= INT_MAX_PCT)
    else $error("intensity above 100");
  a_ld_bus_off: assert property (bus_ld_off |=> laser_diode_off)
    else $error("diode not off after bus request");
  a_ld_off_bit: assert property (laser_diode_off |-> ##2 status_byte[SB_LD_OFF])
    else $error("diode off not reported");
  a_temp_bit: assert property (temp_high |-> ##2 status_byte[SB_TEMP])
    else $error("temperature bit missing");
  a_hw_bit: assert property (hw_fault |-> ##2 status_byte[SB_HW])
    else $error("hardware bit missing");
  a_warn_bit: assert property (meas_intensity < INT_WARN_PCT |-> ##2 status_byte[SB_INT_WARN])
    else $error("intensity warning missing");
  a_err_has_cause: assert property (error_out |-> status_byte != 8'h00)
    else $error("error output without status");
  a_cyc_pos: assert property (cyclic_in[23:0] == position)
    else $error("cyclic position mismatch");
  a_cyc_stat: assert property (cyclic_in[31:24] == 8'h00 || cyclic_in[31:24] == status_byte)
    else $error("cyclic high byte not status");

  c_temp: cover property (status_byte[SB_TEMP]);
  c_err: cover property (error_out);
  c_ld: cover property (laser_diode_off && status_byte[SB_LD_OFF]);
endmodule : rf_err_chk

bind rf_error_io rf_err_chk rf_err_chk_i (.clk(clk), .nrst(nrst), .par_idx(par_idx), .par_rdata(par_rdata),
  .bus_ld_off(bus_ld_off), .meas_intensity(meas_intensity), .temp_high(temp_high), .hw_fault(hw_fault),
  .error_out(error_out), .laser_diode_off(laser_diode_off), .position(position), .status_byte(status_byte),
  .cyclic_in(cyclic_in));

// ---- test/rf_master_model.sv ----
// Fieldbus master output byte and switching-input wiring.
// Assumes the bench calls its tasks; levels change on falling clk edges.
`timescale 1ns/1ps
module rf_master_model (
  input  wire logic clk,        // Device clock
  output logic      bus_ack,    // Output byte bit 3
  output logic      bus_ld_off, // Output byte diode off
  output logic      switch_in   // Switching input level
);
  initial begin
    bus_ack = 1'b0;
    bus_ld_off = 1'b0;
    switch_in = 1'b0;
  end

  // Acknowledge is a level; only its rise counts
  task set_ack(input logic v);
    @(negedge clk);
    bus_ack = v;
  endtask : set_ack

  task set_ld(input logic v);
    @(negedge clk);
    bus_ld_off = v;
  endtask : set_ld

  task set_sw(input logic v);
    @(negedge clk);
    switch_in = v;
  endtask : set_sw
endmodule : rf_master_model

// ---- test/tb_top.sv ----
// Self-checking bench for the error and switching-input block.
// Assumes the master model drives the output byte and switching pin.
`timescale 1ns/1ps
module tb_top;
  import rf_pkg::*;
  typedef struct { int sel; logic [31:0] exp; } rf_note_t;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic par_wr;
  logic [7:0] par_idx;
  logic [7:0] par_wdata;
  logic auto_ld_off;
  logic speed_chk_en;
  logic [23:0] meas_pos;
  logic meas_valid;
  logic [7:0] meas_intensity;
  logic [23:0] preset_pos;
  logic [5:0] c;
  logic [7:0] par_rdata, status_byte;
  logic [23:0] position;
  logic [31:0] cyclic_in;
  logic error_out, laser_diode_off, bus_ack, bus_ld_off, switch_in;
  int miscompares = 0;
  int n_checks = 0;
  rf_note_t q[$];
  rf_note_t n_cur;
  event obs_ev;
  string nm [6] = '{"position", "status_byte", "error_out", "laser_diode_off", "par_rdata", "cyclic_in"};
  int ci [7] = '{1, 1, 0, 2, 4, 3, 4};
  int sb [7] = '{1, 1, 0, 2, 6, 5, 6};
  logic [7:0] v;

  `define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h seen %h", n, e, a); end end

  always #20 clk = ~clk;

  rf_master_model mm (.clk(clk), .bus_ack(bus_ack), .bus_ld_off(bus_ld_off), .switch_in(switch_in));
  rf_error_io rf_error_io_i (.clk(clk), .nrst(nrst), .par_wr(par_wr), .par_idx(par_idx), .par_wdata(par_wdata),
    .par_rdata(par_rdata), .bus_ld_off(bus_ld_off), .bus_ack(bus_ack), .auto_ld_off(auto_ld_off),
    .speed_chk_en(speed_chk_en), .meas_pos(meas_pos), .meas_valid(meas_valid), .meas_intensity(meas_intensity),
    .beam_lost(c[0]), .temp_high(c[1]), .temp_low(c[5]), .hw_fault(c[2]), .overspeed(c[3]),
    .implausible(c[4]), .preset_pos(preset_pos), .switch_in(switch_in), .error_out(error_out),
    .laser_diode_off(laser_diode_off), .position(position), .status_byte(status_byte), .cyclic_in(cyclic_in));

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] pick(input int s);
    case (s)
      0: pick = {8'h0, position};
      1: pick = {24'h0, status_byte};
      2: pick = {31'h0, error_out};
      3: pick = {31'h0, laser_diode_off};
      4: pick = {24'h0, par_rdata};
      default: pick = cyclic_in;
    endcase
  endfunction : pick

  // Monitor drains every note against the settled outputs
  always @(obs_ev) begin
    while (q.size() > 0) begin
      n_cur = q.pop_front();
      `CHK(nm[n_cur.sel], n_cur.exp, pick(n_cur.sel))
    end
  end

  task note(input int s, input logic [31:0] e);
    q.push_back('{s, e});
    ->obs_ev;
  endtask : note

  task w(input int n);
    repeat (n) @(negedge clk);
  endtask : w

  task wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    par_wr = 1'b1;
    par_idx = i;
    par_wdata = d;
    @(negedge clk);
    par_wr = 1'b0;
  endtask : wr

  task rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    par_idx = i;
    @(negedge clk);
    note(4, {24'h0, e});
  endtask : rd

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    par_wr = 1'b0;
    par_idx = 8'h00;
    par_wdata = 8'h00;
    auto_ld_off = 1'b0;
    speed_chk_en = 1'b0;
    meas_pos = 24'h0;
    meas_valid = 1'b1;
    meas_intensity = 8'h32;
    preset_pos = 24'h0;
    c = 6'h0;
    void'($urandom(32'hb0c56f54));
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int i = 10; i < 15; i++) rd(i[7:0], 8'h00);
    rd(8'h10, 8'h00);
    note(1, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = (i < 2) ? 8'h64 + i[7:0] : 8'h0c + 8'($urandom() % 244);
      meas_intensity = v;
      rd(IDX_INTENSITY, (v > 8'h64) ? 8'h64 : v);
    end
    meas_intensity = 8'h32;
    $display("test intensity done");
    for (int s = 0; s < 3; s++) begin
      wr(IDX_SUBST, s[7:0]);
      meas_pos = 24'($urandom());
      w(3);
      note(0, {8'h0, meas_pos});
      c[s == 1 ? 2 : 0] = 1'b1;
      w(3);
      note(0, {8'h0, s == 0 ? 24'h0 : s == 1 ? 24'hffffff : meas_pos});
      c = 6'h0;
    end
    meas_pos = ~meas_pos;
    meas_valid = 1'b0;
    w(3);
    note(0, {8'h0, ~meas_pos});
    meas_valid = 1'b1;
    $display("test substitute done");
    wr(IDX_ERR_FUNC, EOF_TEMP);
    c[1] = 1'b1;
    w(3);
    c[1] = 1'b0;
    w(4);
    note(1, 32'h07);
    note(2, 32'h1);
    mm.set_ack(1'b1);
    w(3);
    note(1, 32'h0);
    c[1] = 1'b1;
    w(3);
    c[1] = 1'b0;
    w(4);
    note(1, 32'h02);
    mm.set_ack(1'b0);
    wr(IDX_SW_FUNC, SWF_ACK);
    mm.set_sw(1'b1);
    w(6);
    note(1, 32'h0);
    mm.set_sw(1'b0);
    $display("test manual ack done");
    wr(IDX_AUTO_ACK, 8'h01);
    speed_chk_en = 1'b1;
    for (int f = 0; f < 7; f++) begin
      wr(IDX_ERR_FUNC, f[7:0]);
      c[ci[f]] = 1'b1;
      w(3);
      note(2, {31'h0, f != 0});
      note(1, {24'h0, 8'h1 << sb[f]});
      c = 6'h0;
      w(4);
      note(1, 32'h0);
    end
    speed_chk_en = 1'b0;
    c[3] = 1'b1;
    w(3);
    note(1, 32'h0);
    c = 6'h0;
    $display("test error output done");
    mm.set_ld(1'b1);
    w(3);
    note(3, 32'h1);
    note(1, 32'h08);
    mm.set_ld(1'b0);
    wr(IDX_SW_FUNC, SWF_LD_OFF);
    mm.set_sw(1'b1);
    w(6);
    note(3, 32'h1);
    note(1, 32'h08);
    auto_ld_off = 1'b1;
    w(3);
    note(3, 32'h0);
    mm.set_sw(1'b0);
    w(3);
    auto_ld_off = 1'b0;
    w(3);
    note(1, 32'h0);
    $display("test diode done");
    wr(IDX_SW_FUNC, SWF_PRESET);
    preset_pos = 24'($urandom());
    mm.set_sw(1'b1);
    w(6);
    mm.set_sw(1'b0);
    note(0, {8'h0, preset_pos});
    wr(IDX_STAT_BUS, 8'h01);
    meas_intensity = 8'h0a;
    c[5] = 1'b1;
    w(4);
    note(1, 32'h12);
    note(0, {8'h0, preset_pos});
    note(5, {8'h12, preset_pos});
    wr(IDX_STAT_BUS, 8'h00);
    w(2);
    note(5, {8'h0, preset_pos});
    $display("test preset done");
    w(2);
    end_sim();
  end
endmodule : tb_top
